// ### energy_meter_irq_flags.sv
// interrupt status and enable registers of the metering front end
// assumes events are one-cycle pulses from the metering datapath on clk
// and a single-cycle special-function register bus from the core
//
// Notes on behaviour
// - summary flag set when enabled flag set
// - summary clears when enabled flags all clear
// - fault mode change sets low bit 5
// - active/reactive sign change set bits 3/4
// - no-load detections set low bits 0-2
// - current-rms no-load entry also sets bit 2
// - pulse events set mid bits 7/6 always
// - accumulator overflows set mid bits 5/4/3
// - accumulator half full sets mid bits 2/1/0
// - end of any reset sets high bit 7
// - new waveform samples set high bit 5
// - current/voltage peak exceed set bits 4/3
// - line-cycle accumulation end sets high bit 2
// - zero-crossing timeout sets high bit 1
// - voltage zero crossing sets high bit 0
// - same-position enable bit raises pending interrupt, except high bit 7, which has no enable bit
// - enabled pulse events raise pending interrupt
// - sign-change source selected by option bit
`timescale 1ns/1ps

module energy_meter_irq_flags #(
    parameter int unsigned HAS_FAULT    = 1,
    parameter int unsigned HAS_REACTIVE = 1
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // special-function register bus
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    // configuration from neighbouring registers
    input  wire logic       sign_detect_source,
    // power sign levels, 1 = negative
    input  wire logic       active_power_sign,
    input  wire logic       reactive_power_sign,
    // power events, one-cycle pulses
    input  wire logic       fault_mode_change,
    input  wire logic       active_noload,
    input  wire logic       reactive_noload,
    input  wire logic       apparent_noload,
    input  wire logic       current_rms_noload_entry,
    // energy events, one-cycle pulses
    input  wire logic       pulse_out_first,
    input  wire logic       pulse_out_second,
    input  wire logic       apparent_accum_overflow,
    input  wire logic       reactive_accum_overflow,
    input  wire logic       active_accum_overflow,
    input  wire logic       apparent_accum_half,
    input  wire logic       reactive_accum_half,
    input  wire logic       active_accum_half,
    // line and waveform events, one-cycle pulses
    input  wire logic       soft_reset_done,
    input  wire logic       waveform_sample_ready,
    input  wire logic       current_peak_exceeded,
    input  wire logic       voltage_peak_exceeded,
    input  wire logic       line_cycle_accum_done,
    input  wire logic       zero_cross_timeout,
    input  wire logic       zero_cross_detect,
    // pending interrupt to the core
    output logic            metering_irq_summary
);
    import irq_flags_pkg::*;

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (HAS_FAULT > 1) begin : g_bad_fault
        $error("HAS_FAULT must be 0 or 1");
    end
    if (HAS_REACTIVE > 1) begin : g_bad_reactive
        $error("HAS_REACTIVE must be 0 or 1");
    end

    // ------------------------------------------------------------
    // variant masks
    // ------------------------------------------------------------
    localparam logic [7:0] FAULT_CUT = (HAS_FAULT == 1) ? 8'h00 : MASK_FAULT_LOW;
    localparam logic [7:0] REACT_LOW = (HAS_REACTIVE == 1) ? 8'h00 : MASK_REACT_LOW;
    localparam logic [7:0] REACT_MID = (HAS_REACTIVE == 1) ? 8'h00 : MASK_REACT_MID;
    localparam logic [7:0] LOW_BITS  = MASK_ST_LOW & ~FAULT_CUT & ~REACT_LOW;
    localparam logic [7:0] MID_BITS  = MASK_ST_MID & ~REACT_MID;
    localparam logic [7:0] HIGH_BITS = MASK_ST_HIGH;
    localparam logic [7:0] EN_LBITS  = MASK_EN_LOW & LOW_BITS;
    localparam logic [7:0] EN_MBITS  = MASK_EN_MID & MID_BITS;
    localparam logic [7:0] EN_HBITS  = MASK_EN_HIGH;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] en_low;
        logic [7:0] en_mid;
        logic [7:0] en_high;
        logic [7:0] st_low;
        logic [7:0] st_mid;
        logic [7:0] st_high;
        logic [7:0] rdata;
        logic       irq;
        logic       boot;
    } irq_state_type;

    irq_state_type state_ff;
    irq_state_type nxt_state;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // flag register update: write of zero clears, set wins over clear
    function automatic logic [7:0] flag_update(
        input logic [7:0] old_val,
        input logic       hit,
        input logic [7:0] wdata,
        input logic [7:0] events,
        input logic [7:0] mask
    );
        logic [7:0] kept;
        kept = hit ? (old_val & wdata) : old_val;
        return (kept | events) & mask;
    endfunction

    // register read decode
    function automatic logic [7:0] read_mux(
        input irq_state_type st,
        input logic [7:0]    addr
    );
        logic [7:0] val;
        case (addr)
            ADDR_EN_LOW:  val = st.en_low;
            ADDR_EN_MID:  val = st.en_mid;
            ADDR_EN_HIGH: val = st.en_high;
            ADDR_ST_LOW:  val = st.st_low;
            ADDR_ST_MID:  val = st.st_mid;
            ADDR_ST_HIGH: val = st.st_high;
            default:      val = READ_UNMAPPED;
        endcase
        return val;
    endfunction

    // ------------------------------------------------------------
    // sign change events
    // ------------------------------------------------------------
    logic active_sign_change;
    logic reactive_sign_change;

    sign_change_detect u_sign (
        .clk                  (clk),
        .sys_rst              (sys_rst),
        .sign_detect_source   (sign_detect_source),
        .active_power_sign    (active_power_sign),
        .reactive_power_sign  (reactive_power_sign),
        .pulse_out_first      (pulse_out_first),
        .pulse_out_second     (pulse_out_second),
        .active_sign_change   (active_sign_change),
        .reactive_sign_change (reactive_sign_change)
    );

    // ------------------------------------------------------------
    // event vectors
    // ------------------------------------------------------------
    logic [7:0] ev_low;
    logic [7:0] ev_mid;
    logic [7:0] ev_high;

    always_comb begin
        ev_low                      = 8'h00;
        ev_low[BIT_FAULT_SIGN]      = fault_mode_change;
        ev_low[BIT_REACTIVE_SIGN]   = reactive_sign_change;
        ev_low[BIT_ACTIVE_SIGN]     = active_sign_change;
        ev_low[BIT_APPARENT_NOLOAD] = apparent_noload | current_rms_noload_entry;
        ev_low[BIT_REACTIVE_NOLOAD] = reactive_noload;
        ev_low[BIT_ACTIVE_NOLOAD]   = active_noload;
    end

    always_comb begin
        ev_mid                    = 8'h00;
        // set regardless of whether the pulse pin is enabled
        ev_mid[BIT_PULSE_SECOND]  = pulse_out_second;
        ev_mid[BIT_PULSE_FIRST]   = pulse_out_first;
        ev_mid[BIT_APPARENT_OVF]  = apparent_accum_overflow;
        ev_mid[BIT_REACTIVE_OVF]  = reactive_accum_overflow;
        ev_mid[BIT_ACTIVE_OVF]    = active_accum_overflow;
        ev_mid[BIT_APPARENT_HALF] = apparent_accum_half;
        ev_mid[BIT_REACTIVE_HALF] = reactive_accum_half;
        ev_mid[BIT_ACTIVE_HALF]   = active_accum_half;
    end

    always_comb begin
        ev_high                   = 8'h00;
        // hardware reset end is marked by the boot cycle
        ev_high[BIT_RESET_DONE]   = state_ff.boot | soft_reset_done;
        ev_high[BIT_WAVEFORM]     = waveform_sample_ready;
        ev_high[BIT_CURRENT_PEAK] = current_peak_exceeded;
        ev_high[BIT_VOLTAGE_PEAK] = voltage_peak_exceeded;
        ev_high[BIT_CYCLE_DONE]   = line_cycle_accum_done;
        ev_high[BIT_ZX_TIMEOUT]   = zero_cross_timeout;
        ev_high[BIT_ZX_DETECT]    = zero_cross_detect;
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic hit_en_low;
    logic hit_en_mid;
    logic hit_en_high;
    logic hit_st_low;
    logic hit_st_mid;
    logic hit_st_high;

    assign hit_en_low  = sfr_wr && (sfr_addr == ADDR_EN_LOW);
    assign hit_en_mid  = sfr_wr && (sfr_addr == ADDR_EN_MID);
    assign hit_en_high = sfr_wr && (sfr_addr == ADDR_EN_HIGH);
    assign hit_st_low  = sfr_wr && (sfr_addr == ADDR_ST_LOW);
    assign hit_st_mid  = sfr_wr && (sfr_addr == ADDR_ST_MID);
    assign hit_st_high = sfr_wr && (sfr_addr == ADDR_ST_HIGH);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [7:0] flags_low;
    logic       pending;

    always_comb begin
        nxt_state      = state_ff;
        nxt_state.boot = 1'b0;

        // enable registers, reserved bits dropped
        if (hit_en_low) begin
            nxt_state.en_low = sfr_wdata & EN_LBITS;
        end
        if (hit_en_mid) begin
            nxt_state.en_mid = sfr_wdata & EN_MBITS;
        end
        if (hit_en_high) begin
            nxt_state.en_high = sfr_wdata & EN_HBITS;
        end

        // status flags: sticky, cleared only by writing zero
        flags_low = flag_update(state_ff.st_low, hit_st_low, sfr_wdata,
                                ev_low, LOW_BITS);
        nxt_state.st_mid = flag_update(state_ff.st_mid, hit_st_mid, sfr_wdata,
                                       ev_mid, MID_BITS);
        nxt_state.st_high = flag_update(state_ff.st_high, hit_st_high, sfr_wdata,
                                        ev_high, HIGH_BITS);

        // summary follows the enabled flags, both ways
        pending = |(flags_low & nxt_state.en_low)
                | |(nxt_state.st_mid & nxt_state.en_mid)
                | |(nxt_state.st_high & nxt_state.en_high);
        nxt_state.st_low              = flags_low;
        nxt_state.st_low[BIT_SUMMARY] = pending;
        nxt_state.irq                 = pending;

        // read data, sampled before this cycle's update
        if (sfr_rd) begin
            nxt_state.rdata = read_mux(state_ff, sfr_addr);
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff.en_low  <= REG_RESET;
            state_ff.en_mid  <= REG_RESET;
            state_ff.en_high <= REG_RESET;
            state_ff.st_low  <= REG_RESET;
            state_ff.st_mid  <= REG_RESET;
            state_ff.st_high <= REG_RESET;
            state_ff.rdata   <= REG_RESET;
            state_ff.irq     <= 1'b0;
            state_ff.boot    <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sfr_rdata            = state_ff.rdata;
    assign metering_irq_summary = state_ff.irq;

endmodule // energy_meter_irq_flags

// ### irq_flags_pkg.sv
// package for the metering interrupt status and enable block
// assumes an 8-bit special-function register bus on the core clock
package irq_flags_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_EN_LOW   = 8'hD9;
    localparam logic [7:0] ADDR_EN_MID   = 8'hDA;
    localparam logic [7:0] ADDR_EN_HIGH  = 8'hDB;
    localparam logic [7:0] ADDR_ST_LOW   = 8'hDC;
    localparam logic [7:0] ADDR_ST_MID   = 8'hDD;
    localparam logic [7:0] ADDR_ST_HIGH  = 8'hDE;

    // ------------------------------------------------------------
    // reset values and read value of unmapped addresses
    // ------------------------------------------------------------
    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // irq_status_low / irq_enable_low bit positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_SUMMARY         = 7;
    localparam int unsigned BIT_FAULT_SIGN      = 5;
    localparam int unsigned BIT_REACTIVE_SIGN   = 4;
    localparam int unsigned BIT_ACTIVE_SIGN     = 3;
    localparam int unsigned BIT_APPARENT_NOLOAD = 2;
    localparam int unsigned BIT_REACTIVE_NOLOAD = 1;
    localparam int unsigned BIT_ACTIVE_NOLOAD   = 0;

    // ------------------------------------------------------------
    // irq_status_mid / irq_enable_mid bit positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_PULSE_SECOND    = 7;
    localparam int unsigned BIT_PULSE_FIRST     = 6;
    localparam int unsigned BIT_APPARENT_OVF    = 5;
    localparam int unsigned BIT_REACTIVE_OVF    = 4;
    localparam int unsigned BIT_ACTIVE_OVF      = 3;
    localparam int unsigned BIT_APPARENT_HALF   = 2;
    localparam int unsigned BIT_REACTIVE_HALF   = 1;
    localparam int unsigned BIT_ACTIVE_HALF     = 0;

    // ------------------------------------------------------------
    // irq_status_high / irq_enable_high bit positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_RESET_DONE      = 7;
    localparam int unsigned BIT_WAVEFORM        = 5;
    localparam int unsigned BIT_CURRENT_PEAK    = 4;
    localparam int unsigned BIT_VOLTAGE_PEAK    = 3;
    localparam int unsigned BIT_CYCLE_DONE      = 2;
    localparam int unsigned BIT_ZX_TIMEOUT      = 1;
    localparam int unsigned BIT_ZX_DETECT       = 0;

    // ------------------------------------------------------------
    // implemented bits (reserved bits read zero)
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_EN_LOW      = 8'h3F;
    localparam logic [7:0] MASK_EN_MID      = 8'hFF;
    localparam logic [7:0] MASK_EN_HIGH     = 8'h3F;
    localparam logic [7:0] MASK_ST_LOW      = 8'h3F;
    localparam logic [7:0] MASK_ST_MID      = 8'hFF;
    localparam logic [7:0] MASK_ST_HIGH     = 8'hBF;
    // bits removed in variants without fault or reactive support
    localparam logic [7:0] MASK_FAULT_LOW   = 8'h20;
    localparam logic [7:0] MASK_REACT_LOW   = 8'h12;
    localparam logic [7:0] MASK_REACT_MID   = 8'h12;

endpackage : irq_flags_pkg

// ### sign_change_detect.sv
// sign-change event source for active and reactive power
// assumes sign levels and pulse strobes come from logic on clk
`timescale 1ns/1ps

module sign_change_detect (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // configuration
    input  wire logic sign_detect_source,
    // power signs, 1 = negative
    input  wire logic active_power_sign,
    input  wire logic reactive_power_sign,
    // pulse output strobes
    input  wire logic pulse_out_first,
    input  wire logic pulse_out_second,
    // sign change events, one-cycle pulses
    output logic      active_sign_change,
    output logic      reactive_sign_change
);
    import irq_flags_pkg::*;

    typedef struct packed {
        logic filt_act;
        logic filt_rea;
        logic pulse_act;
        logic pulse_rea;
        logic seen_act;
        logic seen_rea;
        logic evt_act;
        logic evt_rea;
    } sign_state_type;

    sign_state_type state_ff;
    sign_state_type nxt_state;

    always_comb begin
        nxt_state          = state_ff;
        nxt_state.filt_act = active_power_sign;
        nxt_state.filt_rea = reactive_power_sign;
        nxt_state.evt_act  = 1'b0;
        nxt_state.evt_rea  = 1'b0;
        if (!sign_detect_source) begin
            // filtered power signal
            nxt_state.evt_act = active_power_sign != state_ff.filt_act;
            nxt_state.evt_rea = reactive_power_sign != state_ff.filt_rea;
        end
        // per-pulse: compare sign at this pulse with sign at the last one
        if (pulse_out_first) begin
            if (sign_detect_source && state_ff.seen_act) begin
                nxt_state.evt_act = active_power_sign != state_ff.pulse_act;
            end
            nxt_state.pulse_act = active_power_sign;
            nxt_state.seen_act  = 1'b1;
        end
        if (pulse_out_second) begin
            if (sign_detect_source && state_ff.seen_rea) begin
                nxt_state.evt_rea = reactive_power_sign != state_ff.pulse_rea;
            end
            nxt_state.pulse_rea = reactive_power_sign;
            nxt_state.seen_rea  = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign active_sign_change   = state_ff.evt_act;
    assign reactive_sign_change = state_ff.evt_rea;

endmodule // sign_change_detect

// ### irq_flags_props.sv
// checker for the metering interrupt status and enable block
// assumes it is bound to the block's top module on the core clock
`timescale 1ns/1ps
module irq_flags_props
    import irq_flags_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // register bus
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    // events and pending line
    input wire logic       pulse_out_second,
    input wire logic       active_accum_overflow,
    input wire logic       zero_cross_detect,
    input wire logic       metering_irq_summary
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ----------
    // bus steps
    // ----------
    sequence rd_at(logic [7:0] a);
        sfr_rd && sfr_addr == a;
    endsequence
    sequence wr_en_low;
        sfr_wr && sfr_addr == ADDR_EN_LOW;
    endsequence
    sequence clr_zx;
        sfr_wr && sfr_addr == ADDR_ST_HIGH && !sfr_wdata[0] && !zero_cross_detect;
    endsequence

    // ----------
    // assertions
    // ----------
    summary_read_a: assert property (
        rd_at(ADDR_ST_LOW) |=> sfr_rdata[7] == $past(metering_irq_summary))
        else $error("summary bit differs from pending line");
    summary_drop_a: assert property (
        $fell(metering_irq_summary) |->
        $past(sfr_wr && sfr_addr >= ADDR_EN_LOW && sfr_addr <= ADDR_ST_HIGH))
        else $error("pending line dropped without a register write");
    enable_reserved_a: assert property (
        (rd_at(ADDR_EN_LOW) or rd_at(ADDR_EN_HIGH)) |=> sfr_rdata[7:6] == 2'b00)
        else $error("reserved enable bits read nonzero");
    status_reserved_a: assert property (
        (rd_at(ADDR_ST_LOW) or rd_at(ADDR_ST_HIGH)) |=> !sfr_rdata[6])
        else $error("reserved status bit read nonzero");
    unmapped_read_a: assert property (
        sfr_rd && (sfr_addr < ADDR_EN_LOW || sfr_addr > ADDR_ST_HIGH)
        |=> sfr_rdata == READ_UNMAPPED) else $error("unmapped read nonzero");
    enable_write_a: assert property (
        wr_en_low ##1 rd_at(ADDR_EN_LOW) |=> sfr_rdata == ($past(sfr_wdata, 2) & MASK_EN_LOW))
        else $error("enable readback wrong");
    flag_clear_a: assert property (
        clr_zx ##1 rd_at(ADDR_ST_HIGH) |=> !sfr_rdata[0])
        else $error("zero crossing flag not cleared");
    zx_sets_a: assert property (
        zero_cross_detect ##1 rd_at(ADDR_ST_HIGH) |=> sfr_rdata[0])
        else $error("zero crossing flag not set");
    pulse_sets_a: assert property (
        pulse_out_second ##1 rd_at(ADDR_ST_MID) |=> sfr_rdata[7])
        else $error("second pulse flag not set");
    overflow_sets_a: assert property (
        active_accum_overflow ##1 rd_at(ADDR_ST_MID) |=> sfr_rdata[3])
        else $error("active overflow flag not set");
endmodule // irq_flags_props

bind energy_meter_irq_flags irq_flags_props irq_flags_props_inst (
    .clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .pulse_out_second(pulse_out_second), .active_accum_overflow(active_accum_overflow),
    .zero_cross_detect(zero_cross_detect), .metering_irq_summary(metering_irq_summary));

// ### core_sfr_model.sv
// processor core side of the register bus
// assumes the caller drives it just after a rising clock edge
`timescale 1ns/1ps
module core_sfr_model (
    // register bus toward the block
    output logic [7:0] sfr_addr,
    output logic       sfr_wr,
    output logic [7:0] sfr_wdata,
    output logic       sfr_rd
);
    initial begin
        {sfr_addr, sfr_wr, sfr_wdata, sfr_rd} = '0;
    end

    // op 1 write, 2 read, 3 clear the bits in d, else idle with lines flipped
    task automatic drive(input int op, input logic [7:0] a, input logic [7:0] d);
        sfr_addr = (op >= 1 && op <= 3) ? a : ~sfr_addr;
        sfr_wdata = (op == 1) ? d : (op == 3) ? ~d : ~sfr_wdata;
        sfr_wr = (op == 1 || op == 3);
        sfr_rd = (op == 2);
    endtask
endmodule // core_sfr_model

// ### tb.sv
// testbench for the metering interrupt status and enable block
// assumes the core model drives the bus and the bench drives events
`timescale 1ns/1ps
module tb;
    import irq_flags_pkg::*;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        sign_src = 1'b0;
    logic        aps = 1'b0;
    logic        rps = 1'b0;
    logic [19:0] ev = 20'h00000;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, ra;
    logic        sfr_wr, sfr_rd, metering_irq_summary;
    logic [31:0] seed = 32'hACBE6283;
    int          failures = 0;
    int          total_checks = 0;
    int          st[3], en[3], exp_rd, irq_m, b;
    int          sm[3] = '{MASK_ST_LOW, MASK_ST_MID, MASK_ST_HIGH};
    int          em[3] = '{MASK_EN_LOW, MASK_EN_MID, MASK_EN_HIGH};
    logic        boot, apv, rpv, ad, rdl, ea, er, asv, rsv, asn, rsn;
    logic [7:0]  evs[3];

    initial forever #25 clk = ~clk;

    energy_meter_irq_flags energy_meter_irq_flags_inst (
        .clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .sign_detect_source(sign_src), .active_power_sign(aps), .reactive_power_sign(rps),
        .fault_mode_change(ev[0]), .active_noload(ev[1]), .reactive_noload(ev[2]),
        .apparent_noload(ev[3]), .current_rms_noload_entry(ev[4]),
        .pulse_out_first(ev[5]), .pulse_out_second(ev[6]),
        .apparent_accum_overflow(ev[7]), .reactive_accum_overflow(ev[8]),
        .active_accum_overflow(ev[9]), .apparent_accum_half(ev[10]),
        .reactive_accum_half(ev[11]), .active_accum_half(ev[12]),
        .soft_reset_done(ev[13]), .waveform_sample_ready(ev[14]),
        .current_peak_exceeded(ev[15]), .voltage_peak_exceeded(ev[16]),
        .line_cycle_accum_done(ev[17]), .zero_cross_timeout(ev[18]),
        .zero_cross_detect(ev[19]), .metering_irq_summary(metering_irq_summary));

    core_sfr_model core_sfr_model_inst (
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd));

    // ----------
    // reference model
    // ----------
    function automatic int mreg(input logic [7:0] a);
        if (a >= ADDR_EN_LOW && a <= ADDR_EN_HIGH) return en[a - ADDR_EN_LOW];
        if (a == ADDR_ST_LOW) return st[0] | (irq_m << 7);
        if (a == ADDR_ST_MID || a == ADDR_ST_HIGH) return st[a - ADDR_ST_LOW];
        return 0;
    endfunction

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st = '{0, 0, 0};
            en = '{0, 0, 0};
            {boot, apv, rpv, ad, rdl, asv, rsv, asn, rsn} = 9'h100;
            irq_m = 0;
        end else begin
            if (sfr_rd) exp_rd = mreg(sfr_addr);
            ea = ad;
            er = rdl;
            ad = sign_src ? (ev[5] && asn && aps != asv) : (aps != apv);
            rdl = sign_src ? (ev[6] && rsn && rps != rsv) : (rps != rpv);
            apv = aps;
            rpv = rps;
            if (ev[5]) {asv, asn} = {aps, 1'b1};
            if (ev[6]) {rsv, rsn} = {rps, 1'b1};
            evs[0] = {2'b00, ev[0], er, ea, ev[3] | ev[4], ev[2], ev[1]};
            evs[1] = {ev[6], ev[5], ev[7], ev[8], ev[9], ev[10], ev[11], ev[12]};
            evs[2] = {ev[13] | boot, 1'b0, ev[14], ev[15], ev[16], ev[17], ev[18], ev[19]};
            boot = 1'b0;
            for (int i = 0; i < 3; i++) begin
                if (sfr_wr && sfr_addr == ADDR_ST_LOW + i) st[i] &= sfr_wdata;
                st[i] = (st[i] | evs[i]) & sm[i];
                if (sfr_wr && sfr_addr == ADDR_EN_LOW + i) en[i] = sfr_wdata & em[i];
            end
            irq_m = ((st[0] & en[0]) | (st[1] & en[1]) | (st[2] & en[2])) != 0;
        end
    end

    // ----------
    // bench tasks
    // ----------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic step(input logic [19:0] e, input int op, input logic [7:0] a,
                        input logic [7:0] d);
        ev = e;
        core_sfr_model_inst.drive(op, a, d);
        @(posedge clk);
        #1;
        check("pending line", {7'h00, metering_irq_summary}, irq_m[7:0]);
        if (op == 2) check("read data", sfr_rdata, exp_rd[7:0]);
    endtask

    task automatic rnd_run(input int n);
        logic [31:0] r, e;
        for (int k = 0; k < n; k++) begin
            r = xs();
            e = xs() & xs() & xs();
            if (r[31:29] == 3'h0) aps = ~aps;
            if (r[28:26] == 3'h0) rps = ~rps;
            step(e[19:0], int'(r[1:0]), 8'hD8 + {5'h00, r[10:8]}, r[23:16]);
        end
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------
    // main sequence
    // ----------
    initial begin
        repeat (8) @(posedge clk);
        #1 sys_rst = 1'b0;
        for (b = 0; b < 8; b++) step('0, 2, 8'hD8 + b[7:0], '0);
        for (b = 0; b < 3; b++) begin
            step('0, 1, ADDR_EN_LOW + b[7:0], 8'hFF);
            step('0, 2, ADDR_EN_LOW + b[7:0], '0);
        end
        $display("test registers done");
        for (b = 0; b < 20; b++) begin
            ra = (b < 5) ? ADDR_ST_LOW : (b < 13) ? ADDR_ST_MID : ADDR_ST_HIGH;
            step(20'h00001 << b, 0, '0, '0);
            step('0, 2, ra, '0);
            step('0, 3, ra, 8'hFF);
            step('0, 2, ra, '0);
        end
        step(20'h80000, 3, ADDR_ST_HIGH, 8'hFF);
        step('0, 2, ADDR_ST_HIGH, '0);
        step('0, 1, ADDR_EN_MID, 8'h00);
        step(20'h00040, 3, ADDR_ST_HIGH, 8'hFF);
        step('0, 2, ADDR_ST_MID, '0);
        step('0, 1, ADDR_EN_MID, 8'h80);
        $display("test events done");
        aps = 1'b1;
        step('0, 0, '0, '0);
        step('0, 0, '0, '0);
        step('0, 2, ADDR_ST_LOW, '0);
        rps = 1'b1;
        step('0, 0, '0, '0);
        step('0, 0, '0, '0);
        step('0, 2, ADDR_ST_LOW, '0);
        $display("test signs done");
        rnd_run(400);
        $display("test random filtered done");
        sys_rst = 1'b1;
        sign_src = 1'b1;
        step('0, 0, '0, '0);
        step('0, 0, '0, '0);
        sys_rst = 1'b0;
        step('0, 2, ADDR_ST_HIGH, '0);
        step('0, 2, ADDR_ST_HIGH, '0);
        rnd_run(400);
        $display("test random per pulse done");
        test_done;
    end

    initial begin
        repeat (4000) @(posedge clk);
        failures++;
        test_done;
    end
endmodule // tb
